//--- src/mac_stats.sv
// statistics counter bank with size histograms and register port
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/10ps
`include "mac_stats_map.svh"
module mac_stats (
    input  wire logic                       sys_clk_in,
    input  wire logic                       reset_n_in,
    input  wire logic [8:0]                 reg_addr_in,
    input  wire logic [31:0]                reg_wdata_in,
    input  wire logic                       reg_wr_in,
    input  wire logic                       reg_rd_in,
    output logic      [31:0]                reg_rdata_out,
    input  wire logic [3:0]                 rx_byte_num_in,
    input  wire logic                       rx_symbol_err_in,
    input  wire logic                       rx_proto_err_in,
    input  wire logic                       rx_frame_done_in,
    input  wire mac_stats_pkg::frame_len_t  rx_frame_len_in,
    input  wire logic                       rx_fcs_ok_in,
    input  wire logic                       rx_is_pause_in,
    input  wire logic                       rx_is_bad_opcode_in,
    input  wire logic                       rx_is_single_in,
    input  wire logic                       rx_is_group_in,
    input  wire logic                       rx_is_all_in,
    input  wire logic                       rx_len_mismatch_in,
    input  wire logic                       rx_len_illegal_in,
    input  wire logic [3:0]                 tx_byte_num_in,
    input  wire logic                       tx_frame_done_in,
    input  wire mac_stats_pkg::frame_len_t  tx_frame_len_in,
    input  wire logic                       tx_sent_ok_in,
    input  wire logic                       tx_is_pause_in,
    input  wire logic                       tx_is_single_in,
    input  wire logic                       tx_is_group_in,
    input  wire logic                       tx_is_all_in,
    output logic                            rx_abort_mark_out,
    output logic                            rx_pause_act_out
);
    localparam int N = `NUM_COUNTERS;

    mac_stats_pkg::count_t     cnt_r [N];      // counter bank
    mac_stats_pkg::frame_len_t add   [N];      // per-cycle increments
    logic [N-1:0]              clr;            // software zero write
    mac_stats_pkg::frame_len_t max_frame_length_r; // long-frame limit
    logic [7:0]                hi_snap_r;      // upper byte latched on low read
    mac_stats_pkg::cnt_idx_t   reg_idx;        // addressed register
    logic                      reg_hi;         // upper word select
    logic                      rx_short;       // under 64 bytes
    logic                      rx_long;        // over the limit
    logic                      rx_valid;       // frame counts as good
    logic [2:0]                rx_bin;         // receive size bin
    logic [2:0]                tx_bin;         // transmit size bin

    // true for the four 40-bit byte counters
    function automatic logic is_wide(input mac_stats_pkg::cnt_idx_t ix);
        return (ix == `IX_RX_TOTAL) || (ix == `IX_RX_GOOD) ||
               (ix == `IX_TX_TOTAL) || (ix == `IX_TX_GOOD);
    endfunction : is_wide

    // size bin of a frame, or none when short or long
    function automatic logic [2:0] bin_of(input mac_stats_pkg::frame_len_t len,
                                          input mac_stats_pkg::frame_len_t maxl);
        if (len < `SHORT_LIMIT || len > maxl) begin
            return `NO_BIN;
        end else if (len == `SHORT_LIMIT) begin
            return 3'h0;
        end else if (len <= `BIN1_TOP) begin
            return 3'h1;
        end else if (len <= `BIN2_TOP) begin
            return 3'h2;
        end else if (len <= `BIN3_TOP) begin
            return 3'h3;
        end else if (len <= `BIN4_TOP) begin
            return 3'h4;
        end else if (len <= `BIN5_TOP) begin
            return 3'h5;
        end else begin
            return 3'h6;
        end
    endfunction : bin_of

    assign reg_idx = reg_addr_in[8:3];
    assign reg_hi  = reg_addr_in[2];

    // receive frame classification, plus the transmit size bin
    always_comb begin
        rx_short = rx_frame_len_in < `SHORT_LIMIT;
        rx_long  = rx_frame_len_in > max_frame_length_r;
        rx_valid = rx_fcs_ok_in && !rx_short && !rx_long;
        rx_bin   = bin_of(rx_frame_len_in, max_frame_length_r);
        tx_bin   = bin_of(tx_frame_len_in, max_frame_length_r);
    end

    // increments; frame events only land on the end-of-frame strobe
    always_comb begin
        for (int i = 0; i < N; i++) begin
            add[i] = 14'h0000;
        end
        add[`IX_RX_TOTAL] = 14'(rx_byte_num_in);
        add[`IX_TX_TOTAL] = 14'(tx_byte_num_in);
        add[`IX_RX_SYMBOL] = 14'(rx_symbol_err_in);
        add[`IX_RX_PROTO]  = 14'(rx_proto_err_in);
        if (rx_frame_done_in) begin
            if (rx_valid) begin
                add[`IX_RX_GOOD] = rx_frame_len_in;
            end else begin
                add[`IX_RX_BAD] = rx_frame_len_in;
            end
            add[`IX_RX_FLOW]   = 14'(rx_is_pause_in);
            add[`IX_RX_BADOP]  = 14'(rx_is_bad_opcode_in);
            add[`IX_RX_SINGLE] = 14'(rx_is_single_in);
            add[`IX_RX_GROUP]  = 14'(rx_is_group_in);
            add[`IX_RX_ALL]    = 14'(rx_is_all_in);
            add[`IX_RX_CHECKSUM] = 14'(!rx_fcs_ok_in);
            add[`IX_RX_SHORT_OK]  = 14'(rx_short && rx_fcs_ok_in);
            add[`IX_RX_SHORT_BAD] = 14'(rx_short && !rx_fcs_ok_in);
            add[`IX_RX_LEN_MIS] = 14'(rx_len_mismatch_in);
            add[`IX_RX_LEN_ILL] = 14'(rx_len_illegal_in);
            add[`IX_RX_LONG_OK]  = 14'(rx_long && rx_fcs_ok_in);
            add[`IX_RX_LONG_BAD] = 14'(rx_long && !rx_fcs_ok_in);
            if (rx_bin != `NO_BIN) begin
                add[`IX_RX_HIST0 + 6'(rx_bin)] = 14'h0001;
            end
        end
        if (tx_frame_done_in) begin
            if (tx_sent_ok_in) begin
                add[`IX_TX_GOOD] = tx_frame_len_in;
            end
            add[`IX_TX_FLOW]   = 14'(tx_is_pause_in);
            add[`IX_TX_SINGLE] = 14'(tx_is_single_in);
            add[`IX_TX_GROUP]  = 14'(tx_is_group_in);
            add[`IX_TX_ALL]    = 14'(tx_is_all_in);
            if (tx_bin != `NO_BIN) begin
                add[`IX_TX_HIST0 + 6'(tx_bin)] = 14'h0001;
            end
        end
    end

    // zero write to either word clears the whole counter
    always_comb begin
        for (int i = 0; i < N; i++) begin
            clr[i] = reg_wr_in && (reg_idx == 6'(i)) && (reg_wdata_in == 32'h0000_0000);
        end
    end

    // counter bank; a clear in the event cycle keeps that event
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < N; i++) begin
                cnt_r[i] <= `RST_COUNT;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (clr[i]) begin
                    cnt_r[i] <= 40'(add[i]);
                end else if (is_wide(6'(i))) begin
                    cnt_r[i] <= cnt_r[i] + 40'(add[i]);
                end else begin
                    // narrow counters wrap at 32 bits, upper byte stays zero
                    cnt_r[i] <= (cnt_r[i] + 40'(add[i])) & `NARROW_MASK;
                end
            end
        end
    end

    // long-frame limit, software writable
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            max_frame_length_r <= `RST_MAX_FRAME_LENGTH;
        end else if (reg_wr_in && reg_idx == `IX_MAX_FRAME_LENGTH && !reg_hi) begin
            max_frame_length_r <= reg_wdata_in[13:0];
        end
    end

    // read port; upper word of a 40-bit count is taken at the low read
    // so a low-then-high pair is coherent even while counting
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= 32'h0000_0000;
            hi_snap_r     <= 8'h00;
        end else if (reg_rd_in) begin
            if (reg_idx == `IX_MAX_FRAME_LENGTH) begin
                reg_rdata_out <= reg_hi ? 32'h0000_0000 : 32'(max_frame_length_r);
            end else if (reg_idx < `IX_MAX_FRAME_LENGTH) begin
                if (reg_hi) begin
                    reg_rdata_out <= 32'(hi_snap_r);
                end else begin
                    reg_rdata_out <= cnt_r[reg_idx][31:0];
                    hi_snap_r     <= cnt_r[reg_idx][39:32];
                end
            end else begin
                reg_rdata_out <= 32'h0000_0000; // unmapped reads zero
            end
        end else begin
            reg_rdata_out <= 32'h0000_0000; // data valid one cycle only
        end
    end

    // abort mark and pause action, one cycle after frame end
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_abort_mark_out <= 1'b0;
            rx_pause_act_out  <= 1'b0;
        end else begin
            rx_abort_mark_out <= rx_frame_done_in &&
                (!rx_fcs_ok_in || (rx_is_pause_in && rx_short));
            rx_pause_act_out  <= rx_frame_done_in && rx_is_pause_in &&
                rx_fcs_ok_in && !rx_short;
        end
    end

    // checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_no_wr;
        !reg_wr_in;
    endsequence
    sequence s_short_ok;
        rx_frame_done_in && rx_fcs_ok_in && rx_frame_len_in < `SHORT_LIMIT;
    endsequence
    sequence s_long_bad;
        rx_frame_done_in && !rx_fcs_ok_in && rx_frame_len_in > max_frame_length_r;
    endsequence

    chk_short_split: assert property (s_short_ok and s_no_wr |=>
        cnt_r[`IX_RX_SHORT_OK][31:0] == $past(cnt_r[`IX_RX_SHORT_OK][31:0]) + 32'h1 &&
        cnt_r[`IX_RX_SHORT_BAD] == $past(cnt_r[`IX_RX_SHORT_BAD]))
        else $error("short good frame miscounted");
    chk_long_split: assert property (s_long_bad and s_no_wr |=>
        cnt_r[`IX_RX_LONG_BAD][31:0] == $past(cnt_r[`IX_RX_LONG_BAD][31:0]) + 32'h1 &&
        cnt_r[`IX_RX_LONG_OK] == $past(cnt_r[`IX_RX_LONG_OK]))
        else $error("jabber frame miscounted");
    chk_narrow_wrap: assert property (s_no_wr and (rx_frame_done_in && rx_is_single_in &&
        cnt_r[`IX_RX_SINGLE] == 40'h00_FFFF_FFFF) |=> cnt_r[`IX_RX_SINGLE] == 40'h0)
        else $error("narrow counter did not wrap");
    chk_sw_clear: assert property (reg_wr_in && reg_idx == `IX_RX_CHECKSUM &&
        reg_wdata_in == 32'h0 && !rx_frame_done_in |=> cnt_r[`IX_RX_CHECKSUM] == 40'h0)
        else $error("zero write did not clear");
    chk_total_bytes: assert property (s_no_wr |=>
        cnt_r[`IX_RX_TOTAL] == $past(cnt_r[`IX_RX_TOTAL]) + 40'($past(rx_byte_num_in)))
        else $error("total byte count wrong");
    chk_good_bytes: assert property (s_no_wr and (rx_frame_done_in && rx_valid) |=>
        cnt_r[`IX_RX_GOOD] == $past(cnt_r[`IX_RX_GOOD]) + 40'($past(rx_frame_len_in)))
        else $error("good byte count wrong");
    chk_hist_edge: assert property (s_no_wr and (tx_frame_done_in &&
        tx_frame_len_in == `SHORT_LIMIT) |=>
        cnt_r[`IX_TX_HIST0][31:0] == $past(cnt_r[`IX_TX_HIST0][31:0]) + 32'h1)
        else $error("64 byte bin missed");
    chk_pause_drop: assert property (rx_frame_done_in && rx_is_pause_in &&
        (rx_short || !rx_fcs_ok_in) |=> rx_abort_mark_out && !rx_pause_act_out)
        else $error("bad pause frame acted on");
    chk_read_limit: assert property (reg_rd_in && reg_idx == `IX_MAX_FRAME_LENGTH && !reg_hi
        ##1 !reg_rd_in |-> reg_rdata_out == 32'($past(max_frame_length_r)) ##1
        reg_rdata_out == 32'h0)
        else $error("limit read wrong");
endmodule : mac_stats

//--- src/mac_stats_map.svh
// register map, field positions, reset values and size limits of the statistics bank
`ifndef MAC_STATS_MAP_SVH
`define MAC_STATS_MAP_SVH
// counter indices; byte address = {index, hi_word, 2'b00}
`define IX_RX_TOTAL     6'h00
`define IX_RX_GOOD      6'h01
`define IX_RX_BAD       6'h02
`define IX_TX_TOTAL     6'h03
`define IX_TX_GOOD      6'h04
`define IX_RX_FLOW      6'h05
`define IX_RX_BADOP     6'h06
`define IX_RX_SINGLE    6'h07
`define IX_RX_GROUP     6'h08
`define IX_RX_ALL       6'h09
`define IX_TX_FLOW      6'h0A
`define IX_TX_SINGLE    6'h0B
`define IX_TX_GROUP     6'h0C
`define IX_TX_ALL       6'h0D
`define IX_RX_SYMBOL    6'h0E
`define IX_RX_CHECKSUM  6'h0F
`define IX_RX_SHORT_OK  6'h10
`define IX_RX_SHORT_BAD 6'h11
`define IX_RX_LEN_MIS   6'h12
`define IX_RX_LEN_ILL   6'h13
`define IX_RX_LONG_OK   6'h14
`define IX_RX_LONG_BAD  6'h15
`define IX_RX_PROTO     6'h16
`define IX_RX_HIST0     6'h17
`define IX_TX_HIST0     6'h1E
`define NUM_COUNTERS    37
`define IX_MAX_FRAME_LENGTH      6'h25
// reset values
`define RST_COUNT       40'h00_0000_0000
`define RST_MAX_FRAME_LENGTH     14'h05EE
// size limits
`define SHORT_LIMIT     14'h0040
`define BIN1_TOP        14'h007F
`define BIN2_TOP        14'h00FF
`define BIN3_TOP        14'h01FF
`define BIN4_TOP        14'h03FF
`define BIN5_TOP        14'h05EE
`define NO_BIN          3'h7
`define NARROW_MASK     40'h00_FFFF_FFFF
`endif

//--- src/mac_stats_pkg.sv
// shared types of the statistics bank
package mac_stats_pkg;
    typedef logic [13:0] frame_len_t;  // frame length in bytes
    typedef logic [39:0] count_t;      // widest counter
    typedef logic [5:0]  cnt_idx_t;    // counter index
endpackage : mac_stats_pkg

//--- bench/mac_kernel_model.sv
// behavioural receive and transmit kernels driving the bank's event inputs
`timescale 1ns/10ps
module mac_kernel_model (
    input  wire logic                 clk_in,
    output logic      [3:0]           rx_bytes_out, // receive bytes per cycle
    output logic      [3:0]           tx_bytes_out, // transmit bytes per cycle
    output logic      [1:0]           rx_errs_out,  // protocol, symbol pulses
    output logic                      rx_done_out,  // receive frame end
    output mac_stats_pkg::frame_len_t rx_len_out,
    output logic                      rx_ok_out,
    output logic      [6:0]           rx_kind_out,  // pause badop single group all mis ill
    output logic                      tx_done_out,  // transmit frame end
    output mac_stats_pkg::frame_len_t tx_len_out,
    output logic                      tx_ok_out,
    output logic      [3:0]           tx_kind_out   // pause single group all
);
    // idle link at time zero
    initial begin
        {rx_bytes_out, tx_bytes_out, rx_errs_out, rx_done_out, tx_done_out} = 12'h000;
        {rx_len_out, rx_ok_out, rx_kind_out, tx_len_out, tx_ok_out, tx_kind_out} = 41'h0;
    end
    // qualifiers go stale after the strobe, so a sloppy reader sees junk
    task automatic rx_frame(input mac_stats_pkg::frame_len_t len, input logic ok,
                            input logic [6:0] kind);
        @(posedge clk_in);
        {rx_done_out, rx_len_out, rx_ok_out, rx_kind_out} <= {1'b1, len, ok, kind};
        @(posedge clk_in);
        {rx_done_out, rx_len_out, rx_ok_out, rx_kind_out} <= {1'b0, ~len, ~ok, ~kind};
    endtask : rx_frame
    // one transmitted frame, same stale qualifiers afterwards
    task automatic tx_frame(input mac_stats_pkg::frame_len_t len, input logic ok,
                            input logic [3:0] kind);
        @(posedge clk_in);
        {tx_done_out, tx_len_out, tx_ok_out, tx_kind_out} <= {1'b1, len, ok, kind};
        @(posedge clk_in);
        {tx_done_out, tx_len_out, tx_ok_out, tx_kind_out} <= {1'b0, ~len, ~ok, ~kind};
    endtask : tx_frame
    // byte counts and error pulses held for cyc edges
    task automatic pulses(input logic [3:0] rxn, input logic [3:0] txn,
                          input logic [1:0] err, input int cyc);
        @(posedge clk_in);
        {rx_bytes_out, tx_bytes_out, rx_errs_out} <= {rxn, txn, err};
        repeat (cyc) @(posedge clk_in);
        {rx_bytes_out, tx_bytes_out, rx_errs_out} <= 10'h000;
    endtask : pulses
endmodule : mac_kernel_model

//--- bench/tb_mac_stats.sv
// self-checking bench of the statistics counter bank
`timescale 1ns/10ps
`include "mac_stats_map.svh"
module tb_mac_stats;
    logic                      clk, rst_n, wr, rd, abort, pact;
    logic                      rx_done, rx_ok, tx_done, tx_ok;
    logic [8:0]                addr;
    logic [31:0]               wdata, rdata;
    logic [3:0]                rx_n, tx_n, tx_kind;
    logic [1:0]                errs;
    logic [6:0]                rx_kind;
    mac_stats_pkg::frame_len_t rx_len, tx_len;
    int                        num_errors, checks;
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    mac_kernel_model model (
        .clk_in(clk), .rx_bytes_out(rx_n), .tx_bytes_out(tx_n), .rx_errs_out(errs),
        .rx_done_out(rx_done), .rx_len_out(rx_len), .rx_ok_out(rx_ok),
        .rx_kind_out(rx_kind), .tx_done_out(tx_done), .tx_len_out(tx_len),
        .tx_ok_out(tx_ok), .tx_kind_out(tx_kind)
    );
    mac_stats dut (
        .sys_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .rx_byte_num_in(rx_n), .rx_symbol_err_in(errs[0]), .rx_proto_err_in(errs[1]),
        .rx_frame_done_in(rx_done), .rx_frame_len_in(rx_len), .rx_fcs_ok_in(rx_ok),
        .rx_is_pause_in(rx_kind[6]), .rx_is_bad_opcode_in(rx_kind[5]),
        .rx_is_single_in(rx_kind[4]), .rx_is_group_in(rx_kind[3]), .rx_is_all_in(rx_kind[2]),
        .rx_len_mismatch_in(rx_kind[1]), .rx_len_illegal_in(rx_kind[0]),
        .tx_byte_num_in(tx_n), .tx_frame_done_in(tx_done), .tx_frame_len_in(tx_len),
        .tx_sent_ok_in(tx_ok), .tx_is_pause_in(tx_kind[3]), .tx_is_single_in(tx_kind[2]),
        .tx_is_group_in(tx_kind[1]), .tx_is_all_in(tx_kind[0]),
        .rx_abort_mark_out(abort), .rx_pause_act_out(pact)
    );
    // word compare, reports the address last driven
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: addr %h got %h want %h", $time, addr, got, exp);
        end
    endtask : cmp
    // one-cycle write strobe
    task automatic reg_wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : reg_wr
    // data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [8:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : reg_rd
    // low word first, it latches the high byte
    task automatic chk_cnt(input mac_stats_pkg::cnt_idx_t ix, input mac_stats_pkg::count_t exp);
        logic [31:0] d;
        reg_rd({ix, 3'h0}, d);
        cmp(d, exp[31:0]);
        reg_rd({ix, 3'h4}, d);
        cmp(d, {24'h00_0000, exp[39:32]});
    endtask : chk_cnt
    // every counter clear, limit at 1518, unmapped reads zero
    task automatic t_reset;
        logic [31:0] d;
        for (int i = 0; i < `NUM_COUNTERS; i++) begin
            chk_cnt(6'(i), `RST_COUNT);
        end
        reg_rd({`IX_MAX_FRAME_LENGTH, 3'h0}, d);
        cmp(d, 32'h0000_05EE);
        reg_rd(9'h1F8, d);
        cmp(d, 32'h0000_0000);
    endtask : t_reset
    // one frame of each class at the length boundaries
    task automatic t_rx;
        model.rx_frame(14'h0040, 1'b1, 7'h40);
        #1 cmp({30'h0, abort, pact}, 32'h1);
        @(posedge clk);
        #1 cmp({30'h0, abort, pact}, 32'h0);
        model.rx_frame(14'h0028, 1'b0, 7'h48);
        #1 cmp({30'h0, abort, pact}, 32'h2);
        model.rx_frame(14'h003F, 1'b1, 7'h10);
        model.rx_frame(14'h05EF, 1'b1, 7'h04);
        model.rx_frame(14'h05EE, 1'b0, 7'h00);
        model.rx_frame(14'h0640, 1'b0, 7'h00);
        model.rx_frame(14'h0100, 1'b1, 7'h23);
        chk_cnt(`IX_RX_GOOD, 40'h0140);
        chk_cnt(`IX_RX_BAD, 40'h1284);
        chk_cnt(`IX_RX_FLOW, 40'h2);
        chk_cnt(`IX_RX_GROUP, 40'h1);
        chk_cnt(`IX_RX_SINGLE, 40'h1);
        chk_cnt(`IX_RX_ALL, 40'h1);
        chk_cnt(`IX_RX_BADOP, 40'h1);
        chk_cnt(`IX_RX_CHECKSUM, 40'h3);
        chk_cnt(`IX_RX_SHORT_OK, 40'h1);
        chk_cnt(`IX_RX_SHORT_BAD, 40'h1);
        chk_cnt(`IX_RX_LEN_MIS, 40'h1);
        chk_cnt(`IX_RX_LEN_ILL, 40'h1);
        chk_cnt(`IX_RX_LONG_OK, 40'h1);
        chk_cnt(`IX_RX_LONG_BAD, 40'h1);
        chk_cnt(`IX_RX_HIST0, 40'h1);
        chk_cnt(`IX_RX_HIST0 + 6'h3, 40'h1);
        chk_cnt(`IX_RX_HIST0 + 6'h5, 40'h1);
        chk_cnt(`IX_RX_HIST0 + 6'h6, 40'h0);
    endtask : t_rx
    // bytes every cycle, frames add none here
    task automatic t_bytes;
        model.pulses(4'hF, 4'h9, 2'b01, 5);
        model.pulses(4'h0, 4'h1, 2'b10, 3);
        chk_cnt(`IX_RX_TOTAL, 40'h4B);
        chk_cnt(`IX_TX_TOTAL, 40'h30);
        chk_cnt(`IX_RX_SYMBOL, 40'h5);
        chk_cnt(`IX_RX_PROTO, 40'h3);
    endtask : t_bytes
    // raised limit opens the top bin in transmit
    task automatic t_tx;
        logic [31:0] d;
        reg_wr({`IX_MAX_FRAME_LENGTH, 3'h0}, 32'h0000_07D0);
        reg_rd({`IX_MAX_FRAME_LENGTH, 3'h0}, d);
        cmp(d, 32'h0000_07D0);
        model.tx_frame(14'h05EF, 1'b1, 4'h4);
        model.tx_frame(14'h0040, 1'b0, 4'hB);
        chk_cnt(`IX_TX_GOOD, 40'h05EF);
        chk_cnt(`IX_TX_FLOW, 40'h1);
        chk_cnt(`IX_TX_SINGLE, 40'h1);
        chk_cnt(`IX_TX_GROUP, 40'h1);
        chk_cnt(`IX_TX_ALL, 40'h1);
        chk_cnt(`IX_TX_HIST0, 40'h1);
        chk_cnt(`IX_TX_HIST0 + 6'h6, 40'h1);
    endtask : t_tx
    // nonzero write is ignored, zero to either word clears
    task automatic t_clear;
        reg_wr({`IX_RX_BAD, 3'h0}, 32'h0000_0001);
        chk_cnt(`IX_RX_BAD, 40'h1284);
        reg_wr({`IX_RX_TOTAL, 3'h4}, 32'h0000_0000);
        chk_cnt(`IX_RX_TOTAL, 40'h0);
        reg_wr({`IX_TX_GOOD, 3'h0}, 32'h0000_0000);
        chk_cnt(`IX_TX_GOOD, 40'h0);
        reg_wr({`IX_RX_CHECKSUM, 3'h0}, 32'h0000_0000);
        chk_cnt(`IX_RX_CHECKSUM, 40'h0);
    endtask : t_clear
    // device reset in mid-run clears counts and restores the limit
    task automatic t_mid_reset;
        logic [31:0] d;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk_cnt(`IX_TX_HIST0 + 6'h6, `RST_COUNT);
        reg_rd({`IX_MAX_FRAME_LENGTH, 3'h0}, d);
        cmp(d, 32'h0000_05EE);
    endtask : t_mid_reset
    // counts and verdict
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #100000;
        num_errors++;
        wrap_up;
    end
    // reset for 20 cycles, then the scenarios
    initial begin
        {rst_n, wr, rd, addr, wdata} = 44'h0;
        num_errors = 0;
        checks = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_rx;
        t_bytes;
        t_tx;
        t_clear;
        t_mid_reset;
        wrap_up;
    end
endmodule : tb_mac_stats
